// *** logic/cpm_map.svh ***
// Timing constants and encodings for the charging-port mode control
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
`define CPM_CLK_HZ        100000000
`define CPM_DIS_LONG_MS   2000
`define CPM_DIS_SHORT_MS  250
`define CPM_LOAD_ON_MS    200
`define CPM_LOAD_OFF_MS   3000
`define CPM_DGL_US        8
`define CPM_MS_CYC(ms)    (((ms) * (`CPM_CLK_HZ / 1000)))
`define CPM_US_CYC(us)    (((us) * (`CPM_CLK_HZ / 1000000)))
`define CPM_CTL_OFF       3'h0
`define CPM_CTL_AUTO_A    3'h1
`define CPM_CTL_STANDARD_PORT_ONE_A    3'h2
`define CPM_CTL_AUTO_B    3'h3
`define CPM_CTL_SHORT     3'h4
`define CPM_CTL_DIV1      3'h5
`define CPM_CTL_STANDARD_PORT_ONE_B    3'h6
`define CPM_CTL_STANDARD_PORT_TWO_CDP  3'h7
`endif

// *** logic/cpm_pkg.sv ***
// Types shared by the charging-port mode control
package cpm_pkg;
  typedef enum logic [2:0] {
    CPM_MODE_DISCHARGE = 3'h0,
    CPM_MODE_DCP_AUTO  = 3'h1,
    CPM_MODE_STANDARD_PORT_ONE      = 3'h2,
    CPM_MODE_STANDARD_PORT_TWO      = 3'h3,
    CPM_MODE_CDP       = 3'h4,
    CPM_MODE_SHORTED   = 3'h5,
    CPM_MODE_DIVIDER   = 3'h6
  } cpm_mode_e;
  typedef enum logic [1:0] {
    CPM_ST_RUN  = 2'b00,
    CPM_ST_DISC = 2'b01
  } cpm_state_e;
endpackage

// *** logic/cpm_hold_timer.sv ***
// Condition qualifier: output follows input after it holds for set/clear time
`timescale 1ns/10ps
`default_nettype none
module cpm_hold_timer #(
  parameter int unsigned SET_CYC = 2,
  parameter int unsigned CLR_CYC = 1,
  parameter int unsigned W       = 32
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Condition in, qualified out
  input  wire logic cond_i,
  output logic      qual_o
);
  logic [W-1:0] cnt_reg;
  logic         qual_reg;

  // Count while input disagrees with output; flip when time reached
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg  <= '0;
      qual_reg <= 1'b0;
    end else if (cond_i == qual_reg) begin
      cnt_reg <= '0;
    end else if ((cond_i && (cnt_reg >= W'(SET_CYC - 1))) ||
                 (!cond_i && (cnt_reg >= W'(CLR_CYC - 1)))) begin
      cnt_reg  <= '0;
      qual_reg <= cond_i;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end
  assign qual_o = qual_reg;
endmodule
`default_nettype wire

// *** logic/cpm_mode_ctrl.sv ***
// Charging-port mode decode, discharge sequencing and fault/status output
// Contract
// - Mode 000: switch off, discharge on, data open, status inactive.
// - Mode 001: auto DCP, data open; limit pin high runs power wake.
// - Power wake toggles reduced/high limit; status flags current under 45 mA.
// - Mode 011: auto DCP, high limit; limit pin high enables port management.
// - Modes 010 and 110: standard port one, data closed, limit pin picks.
// - Mode 100: forced shorted DCP, limit pin picks, data open.
// - Mode 101: forced divider DCP, limit pin picks, data open.
// - Mode 111: low pin standard two low limit; high pin CDP managed.
// - No discharge between CDP and standard port two.
// - Discharge: switch off, discharge output, switch on; on SDP/CDP changes.
// - Discharge lasts 2 s from STANDARD_PORT_ONE/CDP, 250 ms leaving DCP.
// - Changes 111 to 011 and 010 to 011 skip discharge for wake.
// - Fault output low during over-temperature or current limit.
// - Current-limit fault is deglitched before reaching the output.
// - After thermal shutdown, switch stays off until cooled, then retries.
// - Data switches close only in SDP/CDP and with enable high.
// - Managed status low after 200 ms over limit, high after 3 s under.
`timescale 1ns/10ps
`default_nettype none
`include "cpm_map.svh"
module cpm_mode_ctrl
  import cpm_pkg::*;
#(
  parameter int unsigned DIS_LONG_CYC  = `CPM_MS_CYC(`CPM_DIS_LONG_MS),
  parameter int unsigned DIS_SHORT_CYC = `CPM_MS_CYC(`CPM_DIS_SHORT_MS),
  parameter int unsigned LOAD_ON_CYC   = `CPM_MS_CYC(`CPM_LOAD_ON_MS),
  parameter int unsigned LOAD_OFF_CYC  = `CPM_MS_CYC(`CPM_LOAD_OFF_MS),
  parameter int unsigned DGL_CYC       = `CPM_US_CYC(`CPM_DGL_US),
  parameter int unsigned WAKE_DGL_CYC  = `CPM_US_CYC(`CPM_DGL_US)
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Mode control pins
  input  wire logic mode_select_bit_a_i,
  input  wire logic mode_select_bit_b_i,
  input  wire logic mode_select_bit_c_i,
  input  wire logic limit_choose_pin_i,
  input  wire logic enable_i,
  // Analog monitor flags
  input  wire logic current_limit_i,
  input  wire logic over_temp_i,
  input  wire logic cooled_i,
  input  wire logic load_above_low_i,
  input  wire logic load_below_wake_i,
  // Power path controls
  output logic      power_switch_on_o,
  output logic      discharge_on_o,
  output logic      data_switch_on_o,
  output logic      sel_upper_limit_o,
  output logic      sel_wake_limit_o,
  output cpm_mode_e mode_o,
  // Open-drain status and fault
  output logic      status_n_o,
  output logic      status_n_oe_o,
  output logic      fault_n_o,
  output logic      fault_n_oe_o
);
  logic [2:0] ctl;
  cpm_mode_e  mode_next;
  cpm_mode_e  mode_reg;
  logic [2:0] ctl_reg;
  cpm_state_e state_reg;
  logic [31:0] dis_cnt_reg;
  logic        dis_start;
  logic [31:0] dis_len;
  logic        thermal_off_reg;
  logic        fault_cl;
  logic        load_busy;
  logic        wake_low;
  logic        managed;
  logic        wake_mode;
  logic        status_act;
  logic        power_reg;
  logic        disch_reg;
  logic        data_reg;
  logic        upper_reg;
  logic        wake_reg;
  logic        status_reg;
  logic        fault_reg;

  assign ctl = {mode_select_bit_a_i, mode_select_bit_b_i, mode_select_bit_c_i};

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  always_comb begin
    mode_next = CPM_MODE_DISCHARGE;
    unique case (ctl)
      `CPM_CTL_OFF:      mode_next = CPM_MODE_DISCHARGE;
      `CPM_CTL_AUTO_A:   mode_next = CPM_MODE_DCP_AUTO;
      `CPM_CTL_AUTO_B:   mode_next = CPM_MODE_DCP_AUTO;
      `CPM_CTL_STANDARD_PORT_ONE_A,
      `CPM_CTL_STANDARD_PORT_ONE_B:   mode_next = CPM_MODE_STANDARD_PORT_ONE;
      `CPM_CTL_SHORT:    mode_next = CPM_MODE_SHORTED;
      `CPM_CTL_DIV1:     mode_next = CPM_MODE_DIVIDER;
      `CPM_CTL_STANDARD_PORT_TWO_CDP: mode_next = limit_choose_pin_i ?
                                     CPM_MODE_CDP : CPM_MODE_STANDARD_PORT_TWO;
    endcase
  end

  function automatic logic is_data_mode(input cpm_mode_e m);
    return (m == CPM_MODE_STANDARD_PORT_ONE) || (m == CPM_MODE_STANDARD_PORT_TWO) ||
           (m == CPM_MODE_CDP);
  endfunction

  function automatic logic is_dcp(input cpm_mode_e m);
    return (m == CPM_MODE_DCP_AUTO) || (m == CPM_MODE_SHORTED) ||
           (m == CPM_MODE_DIVIDER);
  endfunction

  // ---------------------------------------------------------------
  // Discharge trigger and length
  // ---------------------------------------------------------------
  always_comb begin
    dis_start = 1'b0;
    dis_len   = DIS_LONG_CYC;
    if (mode_next != mode_reg) begin
      if (is_data_mode(mode_reg) || is_data_mode(mode_next))
        dis_start = 1'b1;
      if ((mode_reg == CPM_MODE_CDP && mode_next == CPM_MODE_STANDARD_PORT_TWO) ||
          (mode_reg == CPM_MODE_STANDARD_PORT_TWO && mode_next == CPM_MODE_CDP))
        dis_start = 1'b0;
      if ((ctl == `CPM_CTL_AUTO_B) &&
          ((ctl_reg == `CPM_CTL_STANDARD_PORT_TWO_CDP) ||
           (ctl_reg == `CPM_CTL_STANDARD_PORT_ONE_A)))
        dis_start = 1'b0;
      if (mode_next == CPM_MODE_DISCHARGE)
        dis_start = 1'b0;
      if (is_dcp(mode_reg))
        dis_len = DIS_SHORT_CYC;
    end
  end

  // ---------------------------------------------------------------
  // Mode tracking and discharge sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg    <= CPM_MODE_DISCHARGE;
      ctl_reg     <= `CPM_CTL_OFF;
      state_reg   <= CPM_ST_RUN;
      dis_cnt_reg <= 32'h0;
    end else begin
      mode_reg <= mode_next;
      ctl_reg  <= ctl;
      if (dis_start) begin
        state_reg   <= CPM_ST_DISC;
        dis_cnt_reg <= dis_len - 32'h1;
      end else if (state_reg == CPM_ST_DISC) begin
        if (dis_cnt_reg == 32'h0)
          state_reg <= CPM_ST_RUN;
        else
          dis_cnt_reg <= dis_cnt_reg - 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Thermal restart latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
      thermal_off_reg <= 1'b0;
    else if (over_temp_i)
      thermal_off_reg <= 1'b1;
    else if (cooled_i)
      thermal_off_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Qualifiers: current-limit deglitch, load timers
  // ---------------------------------------------------------------
  cpm_hold_timer #(.SET_CYC(DGL_CYC), .CLR_CYC(1)) u_fault_dgl (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .cond_i    (current_limit_i),
    .qual_o    (fault_cl)
  );
  cpm_hold_timer #(.SET_CYC(LOAD_ON_CYC), .CLR_CYC(LOAD_OFF_CYC))
    u_load (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .cond_i    (load_above_low_i && managed),
    .qual_o    (load_busy)
  );
  cpm_hold_timer #(.SET_CYC(WAKE_DGL_CYC), .CLR_CYC(WAKE_DGL_CYC))
    u_wake (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .cond_i    (load_below_wake_i && wake_mode),
    .qual_o    (wake_low)
  );

  assign wake_mode = (mode_reg == CPM_MODE_DCP_AUTO) &&
                     (ctl_reg == `CPM_CTL_AUTO_A) && limit_choose_pin_i;
  assign managed   = ((mode_reg == CPM_MODE_DCP_AUTO) &&
                      (ctl_reg == `CPM_CTL_AUTO_B) && limit_choose_pin_i) ||
                     (mode_reg == CPM_MODE_CDP);
  // Status active: load present (managed) or light load (power wake)
  assign status_act = (managed && load_busy) ||
                      (wake_mode && wake_low);

  // ---------------------------------------------------------------
  // Registered output drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      power_reg  <= 1'b0;
      disch_reg  <= 1'b1;
      data_reg   <= 1'b0;
      upper_reg  <= 1'b0;
      wake_reg   <= 1'b0;
      status_reg <= 1'b0;
      fault_reg  <= 1'b0;
    end else begin
      power_reg  <= enable_i && (mode_reg != CPM_MODE_DISCHARGE) &&
                    (state_reg == CPM_ST_RUN) && !dis_start &&
                    !thermal_off_reg;
      disch_reg  <= (mode_reg == CPM_MODE_DISCHARGE) ||
                    (state_reg == CPM_ST_DISC);
      data_reg   <= enable_i && is_data_mode(mode_reg);
      upper_reg  <= (mode_reg == CPM_MODE_DCP_AUTO) ||
                    (mode_reg == CPM_MODE_CDP) ||
                    limit_choose_pin_i;
      wake_reg   <= wake_mode && wake_low;
      status_reg <= status_act;
      fault_reg  <= over_temp_i || fault_cl;
    end
  end

  assign power_switch_on_o = power_reg;
  assign discharge_on_o    = disch_reg;
  assign data_switch_on_o  = data_reg;
  assign sel_upper_limit_o = upper_reg && !wake_reg;
  assign sel_wake_limit_o  = wake_reg;
  assign mode_o            = mode_reg;
  assign status_n_o        = 1'b0;
  assign status_n_oe_o     = status_reg;
  assign fault_n_o         = 1'b0;
  assign fault_n_oe_o      = fault_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  off_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mode_reg == CPM_MODE_DISCHARGE |=> !power_reg && disch_reg)
    else $error("off mode drives switch");
  off_data_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mode_reg == CPM_MODE_DISCHARGE |=> !data_reg && !status_reg)
    else $error("off mode data or status active");
  data_enable_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !enable_i |=> !data_switch_on_o)
    else $error("data switch closed while disabled");
  dcp_data_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    is_dcp(mode_reg) |=> !data_switch_on_o)
    else $error("data switch closed in dcp");
  no_disch_cdp_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_reg == CPM_MODE_CDP && mode_next == CPM_MODE_STANDARD_PORT_TWO) |-> !dis_start)
    else $error("discharge between cdp and standard_port_two");
  wake_over_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ctl_reg == `CPM_CTL_STANDARD_PORT_ONE_A && ctl == `CPM_CTL_AUTO_B) |-> !dis_start)
    else $error("wake change discharged");
  disch_seq_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    dis_start |=> state_reg == CPM_ST_DISC ##1 !power_reg)
    else $error("discharge did not cut switch");
  disch_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (dis_start && is_dcp(mode_reg)) |=> dis_cnt_reg == DIS_SHORT_CYC - 1)
    else $error("short discharge length wrong");
  thermal_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    over_temp_i |=> thermal_off_reg ##1 !power_reg)
    else $error("switch on after thermal");
  fault_temp_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    over_temp_i |=> fault_n_oe_o)
    else $error("fault not raised on temp");
  fault_glitch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ($rose(current_limit_i) && !over_temp_i && !fault_cl)
      ##1 !current_limit_i && !over_temp_i |=> !fault_n_oe_o)
    else $error("one cycle glitch faulted");

  disch_cov_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    dis_start ##1 state_reg == CPM_ST_DISC);
  cdp_cov_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    mode_reg == CPM_MODE_CDP && status_reg);
  wake_cov_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    wake_reg);
  fault_cov_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    fault_cl);
endmodule
`default_nettype wire

// *** testbench/cpm_host_model.sv ***
// Host controller model that drives the mode and limit pins
`timescale 1ns/10ps
`default_nettype none
module cpm_host_model (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // Requested setting from the bench
  input  wire logic [2:0] want_ctl_i,
  input  wire logic       want_lim_i,
  // Pins toward the device
  output logic            mode_select_bit_a_o,
  output logic            mode_select_bit_b_o,
  output logic            mode_select_bit_c_o,
  output logic            limit_choose_pin_o
);
  logic [2:0] ctl_reg;
  logic       lim_reg;
  // Mode pins; a 110 to 011 move goes through 010 to avoid a stray 111
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_reg <= 3'h0;
    end else if (ctl_reg == 3'h6 && want_ctl_i == 3'h3) begin
      ctl_reg <= 3'h2;
    end else begin
      ctl_reg <= want_ctl_i;
    end
  end
  // Limit pin follows the request
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lim_reg <= 1'b0;
    end else begin
      lim_reg <= want_lim_i;
    end
  end
  assign mode_select_bit_a_o = ctl_reg[2];
  assign mode_select_bit_b_o = ctl_reg[1];
  assign mode_select_bit_c_o = ctl_reg[0];
  assign limit_choose_pin_o  = lim_reg;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the charging-port mode control
`timescale 1ns/10ps
`default_nettype none
module tb
  import cpm_pkg::*;
;
  localparam int L = 50;
  localparam int S = 20;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] want_ctl = 3'h0;
  logic want_lim = 1'b0;
  logic enable = 1'b1;
  logic cur_lim = 1'b0;
  logic hot = 1'b0;
  logic cooled = 1'b0;
  logic load_hi = 1'b0;
  logic load_lo = 1'b0;
  wire logic pa, pb, pc, pl;
  logic power_switch_on_o, discharge_on_o, data_switch_on_o;
  logic sel_upper_limit_o, sel_wake_limit_o, status_n_oe_o, fault_n_oe_o;
  logic status_n_o, fault_n_o;
  cpm_mode_e mode_o;
  int n_fail = 0;
  int comparisons = 0;
  cpm_mode_e em [16] = '{CPM_MODE_DISCHARGE, CPM_MODE_DISCHARGE,
    CPM_MODE_DCP_AUTO, CPM_MODE_DCP_AUTO, CPM_MODE_STANDARD_PORT_ONE, CPM_MODE_STANDARD_PORT_ONE,
    CPM_MODE_DCP_AUTO, CPM_MODE_DCP_AUTO, CPM_MODE_SHORTED,
    CPM_MODE_SHORTED, CPM_MODE_DIVIDER, CPM_MODE_DIVIDER, CPM_MODE_STANDARD_PORT_ONE,
    CPM_MODE_STANDARD_PORT_ONE, CPM_MODE_STANDARD_PORT_TWO, CPM_MODE_CDP};
  logic [15:0] dmask = 16'hf030;
  logic [15:0] umask = 16'haaee;

  // Clock
  always #5 clk_sys_i = ~clk_sys_i;

  cpm_host_model host_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .want_ctl_i(want_ctl), .want_lim_i(want_lim),
    .mode_select_bit_a_o(pa), .mode_select_bit_b_o(pb),
    .mode_select_bit_c_o(pc), .limit_choose_pin_o(pl));

  cpm_mode_ctrl #(.DIS_LONG_CYC(L), .DIS_SHORT_CYC(S), .LOAD_ON_CYC(10),
    .LOAD_OFF_CYC(30), .DGL_CYC(4), .WAKE_DGL_CYC(4)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .mode_select_bit_a_i(pa), .mode_select_bit_b_i(pb),
    .mode_select_bit_c_i(pc), .limit_choose_pin_i(pl),
    .enable_i(enable), .current_limit_i(cur_lim), .over_temp_i(hot),
    .cooled_i(cooled), .load_above_low_i(load_hi),
    .load_below_wake_i(load_lo), .power_switch_on_o(power_switch_on_o),
    .discharge_on_o(discharge_on_o), .data_switch_on_o(data_switch_on_o),
    .sel_upper_limit_o(sel_upper_limit_o),
    .sel_wake_limit_o(sel_wake_limit_o), .mode_o(mode_o),
    .status_n_o(status_n_o), .status_n_oe_o(status_n_oe_o),
    .fault_n_o(fault_n_o),
    .fault_n_oe_o(fault_n_oe_o));

  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", w, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic go(input logic [2:0] c, input logic l);
    @(posedge clk_sys_i);
    want_ctl <= c;
    want_lim <= l;
  endtask

  // Wait for a pending discharge to end, bounded
  task automatic settle();
    int i;
    cyc(4);
    for (i = 0; i < 300 && power_switch_on_o !== 1'b1; i++) cyc(1);
    cyc(3);
  endtask

  // Change mode and count the cycles with the switch off
  task automatic dis(input logic [2:0] c, input logic l, input int e);
    int n;
    int m;
    n = 0;
    m = 0;
    go(c, l);
    repeat (150) begin
      cyc(1);
      if (power_switch_on_o !== 1'b1) n++;
      if (discharge_on_o === 1'b1) m++;
    end
    comparisons++;
    if (n < e || n > e + 3 || (m > 0) != (e > 0)) begin
      n_fail++;
      $display("MISMATCH discharge cycles expected %0d seen %0d", e, n);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      go(i[3:1], i[0]);
      settle();
      chk("mode", {5'h0, em[i]}, {5'h0, mode_o});
      chk("data", {7'h0, dmask[i]}, {7'h0, data_switch_on_o});
      chk("upper", {7'h0, umask[i]}, {7'h0, sel_upper_limit_o});
      chk("power", {7'h0, i > 1}, {7'h0, power_switch_on_o});
      chk("dis", {7'h0, i < 2}, {7'h0, discharge_on_o});
      chk("status", 8'h0, {7'h0, status_n_oe_o});
    end
    chk("status pin", 8'h0, {7'h0, status_n_o});
    chk("fault pin", 8'h0, {7'h0, fault_n_o});
    go(3'h2, 1'b1);
    settle();
    dis(3'h7, 1'b1, L);
    dis(3'h7, 1'b0, 0);
    dis(3'h7, 1'b1, 0);
    dis(3'h3, 1'b0, 0);
    dis(3'h2, 1'b0, S);
    dis(3'h3, 1'b1, 0);
    dis(3'h7, 1'b1, S);
    dis(3'h4, 1'b0, L);
    dis(3'h6, 1'b1, S);
    dis(3'h3, 1'b1, 0);
    dis(3'h2, 1'b1, S);
    go(3'h7, 1'b1);
    cyc(10);
    dis(3'h2, 1'b1, L);
    enable <= 1'b0;
    cyc(3);
    chk("data off", 8'h0, {7'h0, data_switch_on_o});
    enable <= 1'b1;
    cyc(3);
    chk("data on", 8'h1, {7'h0, data_switch_on_o});
    // Single-cycle spike must not reach the fault output
    cur_lim <= 1'b1;
    cyc(1);
    cur_lim <= 1'b0;
    cyc(4);
    chk("pulse", 8'h0, {7'h0, fault_n_oe_o});
    cur_lim <= 1'b1;
    cyc(2);
    cur_lim <= 1'b0;
    cyc(4);
    chk("glitch", 8'h0, {7'h0, fault_n_oe_o});
    cur_lim <= 1'b1;
    cyc(8);
    chk("fault", 8'h1, {7'h0, fault_n_oe_o});
    cur_lim <= 1'b0;
    cyc(3);
    chk("fault off", 8'h0, {7'h0, fault_n_oe_o});
    hot <= 1'b1;
    cyc(2);
    chk("hot fault", 8'h1, {7'h0, fault_n_oe_o});
    chk("hot power", 8'h0, {7'h0, power_switch_on_o});
    hot <= 1'b0;
    cyc(5);
    chk("not cooled", 8'h0, {7'h0, power_switch_on_o});
    cooled <= 1'b1;
    cyc(4);
    chk("restart", 8'h1, {7'h0, power_switch_on_o});
    cooled <= 1'b0;
    go(3'h3, 1'b1);
    settle();
    load_hi <= 1'b1;
    cyc(5);
    chk("load early", 8'h0, {7'h0, status_n_oe_o});
    cyc(10);
    chk("load on", 8'h1, {7'h0, status_n_oe_o});
    load_hi <= 1'b0;
    cyc(15);
    chk("load hold", 8'h1, {7'h0, status_n_oe_o});
    cyc(20);
    chk("load off", 8'h0, {7'h0, status_n_oe_o});
    go(3'h1, 1'b1);
    settle();
    load_lo <= 1'b1;
    cyc(8);
    chk("wake lim", 8'h1, {7'h0, sel_wake_limit_o});
    chk("wake stat", 8'h1, {7'h0, status_n_oe_o});
    chk("wake up", 8'h0, {7'h0, sel_upper_limit_o});
    load_lo <= 1'b0;
    cyc(8);
    chk("busy lim", 8'h1, {7'h0, sel_upper_limit_o});
    test_done();
  end
endmodule
`default_nettype wire
